// ===== rtl/cps_pkg.sv
// Package for the converter protection sequencer: map, fields, resets, states
package cps_pkg;
	localparam int          ADC_W        = 10;
	localparam int          LVL_W        = 11;
	localparam int          DLY_W        = 16;
	localparam int          NVM_W        = 16;
	// APB register byte offsets
	localparam logic [7:0]  A_BO_LEVEL   = 8'h00;
	localparam logic [7:0]  A_BI_LEVEL   = 8'h04;
	localparam logic [7:0]  A_BO_DELAY   = 8'h08;
	localparam logic [7:0]  A_RES_DELAY  = 8'h0c;
	localparam logic [7:0]  A_OTP_LEVEL  = 8'h10;
	localparam logic [7:0]  A_STATUS     = 8'h14;
	localparam logic [7:0]  A_MEAS       = 8'h18;
	localparam logic [7:0]  A_PROT_REC   = 8'h1c;
	// Reset values
	localparam logic [LVL_W-1:0] RST_BO_LEVEL  = 11'h0a0;
	localparam logic [LVL_W-1:0] RST_BI_LEVEL  = 11'h0c0;
	localparam logic [DLY_W-1:0] RST_BO_DELAY  = 16'h0400;
	localparam logic [DLY_W-1:0] RST_RES_DELAY = 16'h0800;
	localparam logic [LVL_W-1:0] RST_OTP_LEVEL = 11'h080;
	// Parameter word fields from the parameter memory
	localparam int          P_OTP_LATCH  = 0;
	localparam int          P_FD_PROT    = 1;
	localparam int          P_FD_LATCH   = 2;
	localparam int          P_OVP_LATCH  = 3;
	localparam int          P_BO_RES     = 4;
	localparam int          P_SENSE_10M  = 5;
	localparam int          P_REC_LSB    = 8;
	// Protection record bits
	localparam int          REC_W        = 3;
	localparam int          REC_NVM      = 0;
	localparam int          REC_SCP      = 1;
	localparam int          REC_OVP      = 2;
	// Pin vector positions
	localparam int          PIN_W        = 5;
	localparam int          PIN_UV       = 0;
	localparam int          PIN_START    = 1;
	localparam int          PIN_OTP      = 2;
	localparam int          PIN_BOOST_OK = 3;
	localparam int          PIN_OVP      = 4;
	// Peak count after which the next peak is a temperature measurement (one peak in four)
	localparam logic [1:0]  PEAK_TEMP    = 2'h3;
	// Safe-restart interval
	localparam int          CLK_MHZ      = 250;
	localparam int          RESTART_US   = 10;
	localparam int          RESTART_CYC  = RESTART_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_NVM     = 3'b001,
		ST_WAIT    = 3'b010,
		ST_RUN     = 3'b011,
		ST_RESTART = 3'b100,
		ST_LATCH   = 3'b101
	} cps_state_t;

	typedef struct packed {
		logic [LVL_W-1:0] bo_level;
		logic [LVL_W-1:0] bi_level;
		logic [DLY_W-1:0] bo_delay;
		logic [DLY_W-1:0] res_delay;
		logic [LVL_W-1:0] otp_level;
	} cps_cfg_t;

	typedef struct packed {
		cps_state_t       state;
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		cps_cfg_t         cfg;
		logic [NVM_W-1:0] par;
		logic             nvm_req;
		logic [REC_W-1:0] rec;
		logic [15:0]      tmr;
		logic [ADC_W-1:0] run_max;
		logic             rising;
		logic [1:0]       peak_cnt;
		logic             temp_sel;
		logic [LVL_W-1:0] mains_peak;
		logic [LVL_W-1:0] temp_val;
		logic             temp_ok;
		logic [DLY_W-1:0] bo_cnt;
		logic             browned;
		logic [DLY_W-1:0] res_cnt;
		logic             res_off;
		logic             boost_en;
		logic             res_en;
		logic             soft_start;
		logic             charge;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} cps_regs_t;
endpackage

// ===== rtl/cps_top.sv
// Protection sequencer for a boost and resonant two-stage supply, APB slave
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module cps_top
	import cps_pkg::*;
#(
	parameter int RESTART_CYCLES = RESTART_CYC
)(
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// APB slave
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [7:0]       paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic                  pready_o,
	output logic                  pslverr_o,
	output logic [31:0]           prdata_o,
	// Comparator pins, asynchronous
	input  wire logic             supply_uv_i,
	input  wire logic             supply_start_i,
	input  wire logic             otp_int_i,
	input  wire logic             boost_sense_ok_i,
	input  wire logic             supply_ovp_i,
	// Mains sense converter, same clock
	input  wire logic             adc_valid_i,
	input  wire logic [ADC_W-1:0] adc_data_i,
	output logic                  temp_sel_o,
	// Parameter memory
	output logic                  nvm_req_o,
	input  wire logic             nvm_done_i,
	input  wire logic             nvm_fail_i,
	input  wire logic [NVM_W-1:0] nvm_data_i,
	// Power stage
	output logic                  boost_en_o,
	output logic                  resonant_en_o,
	output logic                  soft_start_o,
	output logic                  drain_charge_o
);

	cps_regs_t        r_ff;
	cps_regs_t        nxt_r;
	logic [LVL_W-1:0] scaled;
	logic             uv;
	logic             start_ok;
	logic             otp_int;
	logic             boost_ok;
	logic             ovp;
	logic             prot;
	logic             prot_latch;
	logic [REC_W-1:0] rec_set;
	logic             wr_fire;
	logic             rd_phase;
	logic [31:0]      rd_mux;

	always_comb
	begin
		nxt_r      = r_ff;
		uv         = r_ff.sy2[PIN_UV];
		start_ok   = r_ff.sy2[PIN_START];
		otp_int    = r_ff.sy2[PIN_OTP];
		boost_ok   = r_ff.sy2[PIN_BOOST_OK];
		ovp        = r_ff.sy2[PIN_OVP];
		prot       = 1'b0;
		prot_latch = 1'b0;
		rec_set    = '0;
		scaled     = '0;
		rd_mux     = '0;
		wr_fire    = 1'b0;
		rd_phase   = 1'b0;

		// Pins pass two flops before use
		nxt_r.sy1 = {supply_ovp_i, boost_sense_ok_i, otp_int_i, supply_start_i, supply_uv_i};
		nxt_r.sy2 = r_ff.sy1;

		// Mains scaling: 20 megaohm gives half the current of 10 megaohm
		if (r_ff.par[P_SENSE_10M])
			scaled = {1'b0, r_ff.run_max};
		else
			scaled = {r_ff.run_max, 1'b0};

		// Peak detect on the falling edge of the waveform
		if (adc_valid_i)
		begin
			if (adc_data_i > r_ff.run_max)
			begin
				nxt_r.run_max = adc_data_i;
				nxt_r.rising  = 1'b1;
			end
			else if (r_ff.rising && adc_data_i < r_ff.run_max)
			begin
				nxt_r.rising   = 1'b0;
				nxt_r.run_max  = adc_data_i;
				nxt_r.peak_cnt = r_ff.peak_cnt + 2'h1;
				nxt_r.temp_sel = (r_ff.peak_cnt + 2'h1) == PEAK_TEMP;
				if (r_ff.temp_sel)
				begin
					nxt_r.temp_val = {1'b0, r_ff.run_max};
					nxt_r.temp_ok  = {1'b0, r_ff.run_max} >= r_ff.cfg.otp_level;
				end
				else
					nxt_r.mains_peak = scaled;
			end
			// Re-arm from the trough so a falling slope yields no extra peak
			else if (!r_ff.rising)
				nxt_r.run_max = adc_data_i;
		end

		// Brownout with delay, brownin with soft start
		nxt_r.soft_start = 1'b0;
		if (!r_ff.browned)
		begin
			if (r_ff.mains_peak < r_ff.cfg.bo_level)
			begin
				if (r_ff.bo_cnt >= r_ff.cfg.bo_delay)
					nxt_r.browned = 1'b1;
				else
					nxt_r.bo_cnt = r_ff.bo_cnt + 16'h0001;
			end
			else
				nxt_r.bo_cnt = '0;
		end
		else if (r_ff.mains_peak > r_ff.cfg.bi_level)
		begin
			nxt_r.browned    = 1'b0;
			nxt_r.bo_cnt     = '0;
			nxt_r.res_off    = 1'b0;
			nxt_r.res_cnt    = '0;
			nxt_r.soft_start = r_ff.state == ST_RUN;
		end
		else if (r_ff.par[P_BO_RES] && !r_ff.res_off)
		begin
			// Resonant stage rides on the bulk capacitor until its delay ends
			if (r_ff.res_cnt >= r_ff.cfg.res_delay)
				nxt_r.res_off = 1'b1;
			else
				nxt_r.res_cnt = r_ff.res_cnt + 16'h0001;
		end

		// Sequencer
		nxt_r.nvm_req = 1'b0;
		case (r_ff.state)
			ST_OFF:
			begin
				nxt_r.charge = 1'b1;
				if (start_ok && !uv)
				begin
					nxt_r.state   = ST_NVM;
					nxt_r.nvm_req = 1'b1;
				end
			end
			ST_NVM:
			begin
				nxt_r.charge  = !start_ok;
				// One request per attempt; a re-issued request restarts the read
				if (nvm_done_i)
				begin
					if (nvm_fail_i)
					begin
						rec_set[REC_NVM] = 1'b1;
						nxt_r.nvm_req    = 1'b1;
					end
					else
					begin
						nxt_r.par   = nvm_data_i;
						nxt_r.state = ST_WAIT;
					end
				end
			end
			ST_WAIT:
			begin
				nxt_r.charge = 1'b0;
				// No start while a fault that would trip at once is still present
				if (boost_ok && !otp_int && !ovp && r_ff.temp_ok)
				begin
					nxt_r.state      = ST_RUN;
					nxt_r.soft_start = 1'b1;
				end
			end
			ST_RUN:
			begin
				nxt_r.charge = 1'b0;
				// Capacitive-mode handling lives in the stage; no shutdown path here
				if (otp_int || !r_ff.temp_ok)
				begin
					prot       = 1'b1;
					prot_latch = r_ff.par[P_OTP_LATCH];
				end
				else if (ovp)
				begin
					prot             = 1'b1;
					prot_latch       = r_ff.par[P_OVP_LATCH];
					rec_set[REC_OVP] = 1'b1;
				end
				else if (!boost_ok)
				begin
					rec_set[REC_SCP] = 1'b1;
					if (r_ff.par[P_FD_PROT])
					begin
						prot       = 1'b1;
						prot_latch = r_ff.par[P_FD_LATCH];
					end
					else
						nxt_r.state = ST_WAIT;
				end
				if (prot)
				begin
					nxt_r.tmr   = '0;
					nxt_r.state = prot_latch ? ST_LATCH : ST_RESTART;
				end
			end
			ST_RESTART:
			begin
				nxt_r.charge = !start_ok;
				if (r_ff.tmr >= 16'(RESTART_CYCLES - 1))
					nxt_r.state = ST_OFF;
				else
					nxt_r.tmr = r_ff.tmr + 16'h0001;
			end
			ST_LATCH:
			begin
				nxt_r.charge = !start_ok;
			end
			default:
			begin
				nxt_r.state = ST_OFF;
			end
		endcase

		// Undervoltage overrides everything; also the only exit from a latch
		if (uv)
		begin
			nxt_r.state  = ST_OFF;
			nxt_r.charge = 1'b1;
		end

		nxt_r.temp_ok  = nxt_r.temp_ok;
		nxt_r.boost_en = (nxt_r.state == ST_RUN) && !nxt_r.browned;
		nxt_r.res_en   = (nxt_r.state == ST_RUN) && !nxt_r.res_off;

		// APB: one wait state, then completion
		rd_phase = psel_i && penable_i && !r_ff.pready;
		wr_fire  = psel_i && penable_i && r_ff.pready && pwrite_i;
		case (paddr_i)
			A_BO_LEVEL:  rd_mux = 32'(r_ff.cfg.bo_level);
			A_BI_LEVEL:  rd_mux = 32'(r_ff.cfg.bi_level);
			A_BO_DELAY:  rd_mux = 32'(r_ff.cfg.bo_delay);
			A_RES_DELAY: rd_mux = 32'(r_ff.cfg.res_delay);
			A_OTP_LEVEL: rd_mux = 32'(r_ff.cfg.otp_level);
			A_STATUS:    rd_mux = {19'h0, r_ff.par[5:0], r_ff.res_off, r_ff.browned,
			                       r_ff.res_en, r_ff.boost_en, r_ff.state};
			A_MEAS:      rd_mux = {5'h0, r_ff.temp_val, 5'h0, r_ff.mains_peak};
			A_PROT_REC:  rd_mux = 32'(r_ff.rec);
			default:     rd_mux = '0;
		endcase
		nxt_r.pready = rd_phase;
		if (rd_phase)
		begin
			nxt_r.prdata  = pwrite_i ? 32'h0000_0000 : rd_mux;
			nxt_r.pslverr = paddr_i[1:0] != 2'h0 || paddr_i > A_PROT_REC;
		end
		else
			nxt_r.pslverr = 1'b0;

		if (wr_fire)
		begin
			case (paddr_i)
				A_BO_LEVEL:  nxt_r.cfg.bo_level  = pwdata_i[LVL_W-1:0];
				A_BI_LEVEL:  nxt_r.cfg.bi_level  = pwdata_i[LVL_W-1:0];
				A_BO_DELAY:  nxt_r.cfg.bo_delay  = pwdata_i[DLY_W-1:0];
				A_RES_DELAY: nxt_r.cfg.res_delay = pwdata_i[DLY_W-1:0];
				A_OTP_LEVEL: nxt_r.cfg.otp_level = pwdata_i[LVL_W-1:0];
				default:     nxt_r.cfg           = r_ff.cfg;
			endcase
		end

		// Write-one clears; a new event in the same cycle wins
		if (wr_fire && paddr_i == A_PROT_REC)
			nxt_r.rec = (r_ff.rec & ~pwdata_i[REC_W-1:0]) | (rec_set & r_ff.par[P_REC_LSB +: REC_W]);
		else
			nxt_r.rec = r_ff.rec | (rec_set & r_ff.par[P_REC_LSB +: REC_W]);
		// Memory fail is recorded before any parameter exists
		if (rec_set[REC_NVM])
			nxt_r.rec[REC_NVM] = 1'b1;
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			r_ff               <= '0;
			r_ff.state         <= ST_OFF;
			r_ff.cfg.bo_level  <= RST_BO_LEVEL;
			r_ff.cfg.bi_level  <= RST_BI_LEVEL;
			r_ff.cfg.bo_delay  <= RST_BO_DELAY;
			r_ff.cfg.res_delay <= RST_RES_DELAY;
			r_ff.cfg.otp_level <= RST_OTP_LEVEL;
			r_ff.temp_ok       <= 1'b1;
			r_ff.browned       <= 1'b1;
			r_ff.charge        <= 1'b1;
		end
		else
			r_ff <= nxt_r;
	end

	assign pready_o       = r_ff.pready;
	assign pslverr_o      = r_ff.pslverr;
	assign prdata_o       = r_ff.prdata;
	assign temp_sel_o     = r_ff.temp_sel;
	assign nvm_req_o      = r_ff.nvm_req;
	assign boost_en_o     = r_ff.boost_en;
	assign resonant_en_o  = r_ff.res_en;
	assign soft_start_o   = r_ff.soft_start;
	assign drain_charge_o = r_ff.charge;

endmodule // cps_top
`default_nettype wire

// ===== verif/cps_sva.sv
// Port assertions for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module cps_sva
	import cps_pkg::*;
(
	// Clock, reset and bus
	input wire logic	clock_i,
	input wire logic	rst_i,
	input wire logic	psel_i,
	input wire logic	penable_i,
	input wire logic [7:0]	paddr_i,
	input wire logic	pready_o,
	input wire logic	pslverr_o,
	// Pins and stages
	input wire logic	supply_uv_i,
	input wire logic	otp_int_i,
	input wire logic	boost_sense_ok_i,
	input wire logic	supply_ovp_i,
	input wire logic	nvm_req_o,
	input wire logic	nvm_done_i,
	input wire logic	nvm_fail_i,
	input wire logic	boost_en_o,
	input wire logic	resonant_en_o,
	input wire logic	soft_start_o,
	input wire logic	drain_charge_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Four cycles cover two sync stages plus the state register
	wire logic	off = !boost_en_o && !resonant_en_o;
	property p_uv; supply_uv_i [*4] |-> off; endproperty
	a_uv: assert property (p_uv) else $error("stages run in undervoltage");
	property p_otp; otp_int_i [*4] |-> off; endproperty
	a_otp: assert property (p_otp) else $error("stages run when hot");
	property p_bs; !boost_sense_ok_i [*4] |-> off; endproperty
	a_bs: assert property (p_bs) else $error("stages run with sense low");
	property p_ovp; supply_ovp_i [*4] |-> off; endproperty
	a_ovp: assert property (p_ovp) else $error("stages run in overvoltage");
	property p_chg; boost_en_o |-> !drain_charge_o; endproperty
	a_chg: assert property (p_chg) else $error("drain charge while running");
	property p_nvm; nvm_req_o |-> off; endproperty
	a_nvm: assert property (p_nvm) else $error("memory read while running");
	property p_rty; nvm_done_i && nvm_fail_i |-> ##[1:8] nvm_req_o; endproperty
	a_rty: assert property (p_rty) else $error("failed read not retried");
	property p_ss;
		$rose(boost_en_o) |-> ($past(soft_start_o) || soft_start_o) or (##1 soft_start_o);
	endproperty
	a_ss: assert property (p_ss) else $error("boost restart without soft start");
	property p_ws; psel_i && penable_i && !pready_o |=> pready_o; endproperty
	a_ws: assert property (p_ws) else $error("bus wait state not one cycle");
	property p_one; pready_o |=> !pready_o; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_err; pready_o && (paddr_i[1:0] != 2'h0 || paddr_i > 8'h1c) |-> pslverr_o; endproperty
	a_err: assert property (p_err) else $error("bad address not refused");
	c_ss: cover property ($rose(boost_en_o));
	c_rty: cover property (nvm_done_i && nvm_fail_i);
	c_err: cover property (pready_o && pslverr_o);
endmodule // cps_sva
bind cps_top cps_sva cps_sva_inst (.*);
`default_nettype wire

// ===== verif/cps_model.sv
// Parameter memory and mains sense network model
`timescale 1ns/1ps
`default_nettype none
module cps_model
	import cps_pkg::*;
(
	input wire logic	clock_i,
	input wire logic	nvm_req_i,
	input wire logic [NVM_W-1:0]	par_i,
	input wire logic [ADC_W-1:0]	amp_i,
	input wire logic [ADC_W-1:0]	temp_i,
	input wire logic	temp_sel_i,
	output logic	done_o,
	output logic	fail_o,
	output logic [NVM_W-1:0]	data_o,
	output logic	valid_o,
	output logic [ADC_W-1:0]	adc_o
);
	int	left = 0;
	logic [2:0]	cnt = 3'h0;
	logic [1:0]	dv = 2'h0;
	logic	dn = 1'b0;
	logic [ADC_W-1:0]	tv = 10'h0;
	initial {done_o, fail_o, data_o, valid_o, adc_o} = '0;
	always @(posedge clock_i)
	begin
		// Idle data lines toggle so no stale value is read
		{done_o, fail_o, data_o, adc_o} <= {2'b0, ~data_o, ~adc_o};
		dv <= dv + 2'h1;
		valid_o <= dv == 2'h3;
		if (dv == 2'h3)
		begin
			adc_o <= temp_sel_i ? temp_i + tv : tv;
			tv <= dn ? tv - 10'h8 : tv + 10'h8;
			dn <= dn ? tv > 10'h8 : tv + 10'h8 >= amp_i;
		end
		if (nvm_req_i) cnt <= 3'h5;
		else if (cnt != 3'h0)
		begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1)
			begin
				{done_o, fail_o, data_o} <= {1'b1, left > 0, par_i};
				if (left > 0) left <= left - 1;
			end
		end
	end
endmodule // cps_model
`default_nettype wire

// ===== verif/cps_top_tb.sv
// Self-checking bench for the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module cps_top_tb
	import cps_pkg::*;
;
	logic	clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [7:0]	paddr_i = 0;
	logic [31:0]	pwdata_i = 0, prdata_o, q;
	logic	pready_o, pslverr_o, e, temp_sel_o, nvm_req_o, nvm_done_i, nvm_fail_i;
	logic	supply_uv_i = 0, supply_start_i = 0, otp_int_i = 0, supply_ovp_i = 0;
	logic	boost_sense_ok_i = 1, adc_valid_i, boost_en_o, resonant_en_o;
	logic	soft_start_o, drain_charge_o;
	logic [NVM_W-1:0]	nvm_data_i, par = 16'h0708;
	logic [ADC_W-1:0]	adc_data_i, amp = 10'd200, temp = 10'h200;
	logic [2:0]	lp;
	logic	ts_q = 1'b0;
	int	ts_n = 0;
	int	mismatches = 0, checks = 0, seed = 93;
	logic [7:0]	ra[5] = '{A_BO_LEVEL, A_BI_LEVEL, A_BO_DELAY, A_RES_DELAY, A_OTP_LEVEL};
	logic [31:0]	rv[5] = '{32'h0a0, 32'h0c0, 32'h400, 32'h800, 32'h080};
	cps_top #(.RESTART_CYCLES(20)) cps_top_inst (.*);
	cps_model cps_model_inst (.clock_i, .nvm_req_i(nvm_req_o), .par_i(par), .amp_i(amp),
		.temp_i(temp), .temp_sel_i(temp_sel_o), .done_o(nvm_done_i), .fail_o(nvm_fail_i),
		.data_o(nvm_data_i), .valid_o(adc_valid_i), .adc_o(adc_data_i));
	initial forever #2 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		ts_q <= temp_sel_o;
		if (temp_sel_o && !ts_q) ts_n++;
	end
	function automatic logic [31:0] st(input logic [2:0] s, input logic [3:0] f);
		return {19'h0, par[5:0], f, s};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		{psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1 && n++ < 20) @(posedge clock_i);
		{q, e} = {prdata_o, pslverr_o};
		{psel_i, penable_i} <= 2'b0;
		@(posedge clock_i);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task automatic wait_st(input logic [2:0] s);
		int n = 0;
		do
			apb(1'b0, A_STATUS, 32'h0);
		while (q[2:0] !== s && n++ < 500);
		chk(32'(q[2:0]), 32'(s));
	endtask
	task automatic rec(input logic [31:0] x);
		rdc(A_PROT_REC, x);
		apb(1'b1, A_PROT_REC, x);
		rdc(A_PROT_REC, 32'h0);
	endtask
	task automatic recycle;
		supply_uv_i <= 1'b1;
		wait_st(ST_OFF);
		chk(32'(drain_charge_o), 32'h1);
		supply_uv_i <= 1'b0;
		wait_st(ST_RUN);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#400000;
		mismatches++;
		close_out;
	end
	initial
	begin
		par = par | 16'($random(seed) & 32'h31);
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		for (int i = 0; i < 5; i++) rdc(ra[i], rv[i]);
		rdc(A_STATUS, 32'h20);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, i ? 8'h20 : 8'h02, $random(seed));
			chk(q, 32'h0);
			chk(32'(e), 32'h1);
		end
		apb(1'b1, A_STATUS, 32'hffff);
		rdc(A_STATUS, 32'h20);
		for (int i = 2; i < 4; i++)
		begin
			rv[i] = 32'd16 + ($random(seed) & 32'h1f);
			apb(1'b1, ra[i], rv[i]);
			rdc(ra[i], rv[i]);
		end
		cps_model_inst.left <= 2;
		supply_start_i <= 1'b1;
		wait_st(ST_RUN);
		rec(32'h1);
		ts_n = 0;
		repeat (1500) @(posedge clock_i);
		apb(1'b0, A_MEAS, 32'h0);
		chk(32'(ts_n >= 2 && ts_n <= 3), 32'h1);
		chk(32'(q[10:0]), par[5] ? 32'(amp) : 32'(amp) << 1);
		chk(32'(q[26:16] >= temp), 32'h1);
		rdc(A_STATUS, st(ST_RUN, 4'h3));
		amp <= 10'd64;
		repeat (1500) @(posedge clock_i);
		rdc(A_STATUS, st(ST_RUN, {par[4], 1'b1, !par[4], 1'b0}));
		amp <= 10'd200 + 10'($random(seed) & 32'h7) * 10'd8;
		repeat (1500) @(posedge clock_i);
		chk(32'(boost_en_o), 32'h1);
		boost_sense_ok_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		chk(32'({boost_en_o, resonant_en_o}), 32'h0);
		wait_st(ST_WAIT);
		rec(32'h2);
		boost_sense_ok_i <= 1'b1;
		wait_st(ST_RUN);
		lp = par[0] ? ST_LATCH : ST_RESTART;
		{amp, temp} <= {10'd64, 10'h0};
		wait_st(lp);
		{amp, temp} <= {10'd200, 10'h200};
		if (!par[0]) wait_st(ST_RUN);
		recycle;
		otp_int_i <= 1'b1;
		wait_st(lp);
		otp_int_i <= 1'b0;
		recycle;
		supply_ovp_i <= 1'b1;
		wait_st(ST_LATCH);
		supply_ovp_i <= 1'b0;
		rec(32'h4);
		supply_start_i <= 1'b0;
		repeat (8) @(posedge clock_i);
		chk(32'(drain_charge_o), 32'h1);
		supply_start_i <= 1'b1;
		repeat (8) @(posedge clock_i);
		chk({29'h0, drain_charge_o, boost_en_o, resonant_en_o}, 32'h0);
		recycle;
		close_out;
	end
endmodule // cps_top_tb
`default_nettype wire
